// >>> common/cmpc_pkg.sv
// Register map, field positions and codes of the comparator control block
package cmpc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CMPC_CTRL_ADDR  = 8'h9e;
    localparam logic [7:0] CMPC_CTRL_RESET = 8'h00;

    // ************************************************************
    // Field positions of comparator_control
    // ************************************************************
    localparam int unsigned CMPC_EN_BIT   = 7;
    localparam int unsigned CMPC_RES_BIT  = 6;
    localparam int unsigned CMPC_RISE_BIT = 5;
    localparam int unsigned CMPC_FALL_BIT = 4;
    localparam int unsigned CMPC_HYP_LSB  = 2;
    localparam int unsigned CMPC_HYN_LSB  = 0;
    localparam int unsigned CMPC_HYS_W    = 2;

    // ************************************************************
    // Hysteresis codes, same for both sides
    // ************************************************************
    typedef enum logic [1:0] {
        CMPC_HYS_OFF  = 2'h0,
        CMPC_HYS_2MV  = 2'h1,
        CMPC_HYS_4MV  = 2'h2,
        CMPC_HYS_10MV = 2'h3
    } cmpc_hys_t;

    // ************************************************************
    // Settling interval after enable, for software polling loops
    // ************************************************************
    localparam int unsigned CMPC_CLK_PERIOD_NS = 20;
    localparam int unsigned CMPC_SETTLE_NS     = 20000;
    localparam int unsigned CMPC_SETTLE_CYC    = CMPC_SETTLE_NS / CMPC_CLK_PERIOD_NS;

endpackage

// >>> common/cmpc_evt_if.sv
// Synchronised comparator level and edge events between conditioner and register
`timescale 1ns/1ps
`default_nettype none
interface cmpc_evt_if;
    logic level;
    logic rise;
    logic fall;

    modport src (
        output level,
        output rise,
        output fall
    );
    modport dst (
        input level,
        input rise,
        input fall
    );
endinterface
`default_nettype wire

// >>> src/cmpc_sync.sv
// Comparator output synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module cmpc_sync (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic arm_i,
    input  wire logic cmp_async_i,
    cmpc_evt_if.src   evt
);
    import cmpc_pkg::*;

    logic       meta_q;
    logic       sync_q;
    logic       prev_q;
    logic [1:0] edge_w;

    // ************************************************************
    // Two-stage synchroniser, history runs even when disarmed
    // ************************************************************
    // sync before edges
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce_i) begin
            meta_q <= cmp_async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ************************************************************
    // Edge events, one per transition while armed
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_edge
            assign edge_w[g] = arm_i & (sync_q ^ prev_q) & (sync_q == 1'(g));
        end
    endgenerate

    assign evt.level = sync_q;
    assign evt.rise  = edge_w[1];
    assign evt.fall  = edge_w[0];

    sequence s_rise_seen;
        ce_i && evt.rise;
    endsequence

    sequence s_fall_seen;
        ce_i && evt.fall;
    endsequence

    chk_rise_single: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_rise_seen |=> !evt.rise)
        else $error("rise event lasted more than one cycle");

    chk_fall_single: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_fall_seen |=> !evt.fall)
        else $error("fall event lasted more than one cycle");

endmodule
`default_nettype wire

// >>> src/cmpc_ctrl.sv
// Comparator control register: enable, result, edge flags and hysteresis codes
`timescale 1ns/1ps
`default_nettype none
module cmpc_ctrl (
    input  wire logic                         clk_sys_i,
    input  wire logic                         nrst_i,
    input  wire logic                         ce_i,
    input  wire logic [7:0]                   sfr_addr_i,
    input  wire logic                         sfr_wr_i,
    input  wire logic                         sfr_rd_i,
    input  wire logic [7:0]                   sfr_wdata_i,
    output logic      [7:0]                   sfr_rdata_o,
    input  wire logic                         cmp_async_i,
    output logic                              comparator_enable_o,
    output logic      [cmpc_pkg::CMPC_HYS_W-1:0] positive_hysteresis_sel_o,
    output logic      [cmpc_pkg::CMPC_HYS_W-1:0] negative_hysteresis_sel_o,
    output logic                              cmp_pin_o
);
    import cmpc_pkg::*;

    cmpc_evt_if evt ();

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] rdata_q;
    logic       pin_q;
    logic       en_w;
    logic       wr_hit_w;
    logic       rd_hit_w;
    logic       rise_set_w;
    logic       fall_set_w;
    logic [7:0] view_w;

    // ************************************************************
    // Input conditioner
    // ************************************************************
    // events suspended when off
    cmpc_sync u_sync (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .arm_i       (en_w),
        .cmp_async_i (cmp_async_i),
        .evt         (evt.src)
    );

    // ************************************************************
    // Decode and next value
    // ************************************************************
    assign en_w       = ctrl_q[CMPC_EN_BIT];
    assign wr_hit_w   = sfr_wr_i && (sfr_addr_i == CMPC_CTRL_ADDR);
    assign rd_hit_w   = sfr_rd_i && (sfr_addr_i == CMPC_CTRL_ADDR);
    assign rise_set_w = evt.rise;
    assign fall_set_w = evt.fall;

    // Result bit is never stored; the read path takes it live
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_hit_w) begin
            ctrl_d = sfr_wdata_i;
            ctrl_d[CMPC_RES_BIT] = 1'b0;
        end
        ctrl_d[CMPC_RISE_BIT] = ctrl_d[CMPC_RISE_BIT] | rise_set_w;
        ctrl_d[CMPC_FALL_BIT] = ctrl_d[CMPC_FALL_BIT] | fall_set_w;
    end

    assign view_w = {ctrl_q[7], evt.level, ctrl_q[5:0]};

    // ************************************************************
    // Registers
    // ************************************************************
    // only a software write or reset clears flags
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ctrl_q <= CMPC_CTRL_RESET;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
        end
    end

    // Read data holds until the next read of this address
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i && rd_hit_w) begin
            rdata_q <= view_w;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            pin_q <= 1'b0;
        end else if (ce_i) begin
            pin_q <= ctrl_d[CMPC_EN_BIT] & evt.level;
        end
    end

    // ************************************************************
    // Outputs to the analog section, the bus and the comparator pin
    // ************************************************************
    // enable drives power-down
    assign comparator_enable_o = en_w;
    assign positive_hysteresis_sel_o = ctrl_q[CMPC_HYP_LSB +: CMPC_HYS_W];
    assign negative_hysteresis_sel_o = ctrl_q[CMPC_HYN_LSB +: CMPC_HYS_W];
    assign sfr_rdata_o = rdata_q;
    assign cmp_pin_o   = pin_q;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_write;
        ce_i && wr_hit_w;
    endsequence

    sequence s_read;
        ce_i && rd_hit_w;
    endsequence

    chk_enable_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_write |=> comparator_enable_o == $past(sfr_wdata_i[7]))
        else $error("enable bit did not follow the write");

    chk_result_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_read |=> sfr_rdata_o[6] == $past(evt.level))
        else $error("result bit does not show the comparator level");

    chk_rise_sets: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ce_i && evt.rise |=> ctrl_q[5])
        else $error("rise flag not set after rising edge");

    chk_fall_sets: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ce_i && evt.fall |=> ctrl_q[4])
        else $error("fall flag not set after falling edge");

    chk_hyst_pos: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_write |=> positive_hysteresis_sel_o == $past(sfr_wdata_i[3:2]))
        else $error("positive hysteresis code wrong after write");

    chk_hyst_neg: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_write ##1 !(ce_i && wr_hit_w) [*2] |->
            negative_hysteresis_sel_o == $past(sfr_wdata_i[1:0], 2))
        else $error("negative hysteresis code wrong or not held");

    chk_flag_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctrl_q[5] && ctrl_q[4] && !(ce_i && wr_hit_w) |=> ctrl_q[5] && ctrl_q[4])
        else $error("edge flag cleared without a software write");

    chk_off_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ctrl_q[7] && !(ce_i && wr_hit_w) |=> !$rose(ctrl_q[5]) && !$rose(ctrl_q[4])
            && !cmp_pin_o)
        else $error("disabled comparator raised an event or drove the pin");

endmodule
`default_nettype wire

// >>> sim/cmpc_ctrl_tb_top.sv
// Self-checking bench for the comparator control register
`timescale 1ns/1ps
`default_nettype none
module cmpc_ctrl_tb_top;
    import cmpc_pkg::*;
    logic       clk_sys_i;
    logic       nrst_i;
    logic       ce_i;
    logic [7:0] sfr_addr_i;
    logic       sfr_wr_i;
    logic       sfr_rd_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic       cmp_async_i;
    logic       comparator_enable_o;
    logic [1:0] positive_hysteresis_sel_o;
    logic [1:0] negative_hysteresis_sel_o;
    logic       cmp_pin_o;
    logic [7:0] m;
    logic [7:0] w;
    int         seed;
    int         miscompares;
    int         n_checks;

    cmpc_ctrl uut (
        .clk_sys_i                 (clk_sys_i),
        .nrst_i                    (nrst_i),
        .ce_i                      (ce_i),
        .sfr_addr_i                (sfr_addr_i),
        .sfr_wr_i                  (sfr_wr_i),
        .sfr_rd_i                  (sfr_rd_i),
        .sfr_wdata_i               (sfr_wdata_i),
        .sfr_rdata_o               (sfr_rdata_o),
        .cmp_async_i               (cmp_async_i),
        .comparator_enable_o       (comparator_enable_o),
        .positive_hysteresis_sel_o (positive_hysteresis_sel_o),
        .negative_hysteresis_sel_o (negative_hysteresis_sel_o),
        .cmp_pin_o                 (cmp_pin_o)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // Expected read value: stored bits with the live level in bit 6
    function automatic logic [7:0] exp_rd(input logic [7:0] r, input logic lvl);
        return {r[7], lvl, r[5:0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
            miscompares++;
        end
    endtask

    // Extra tick so the effect is settled whatever the output latency
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
        tick(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        tick(1);
        sfr_rd_i = 1'b0;
        tick(1);
        chk(sfr_rdata_o, exp, "read data");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Settling wait of about 1000 cycles plus well under 1000 for the rest
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        $display("BAD t=%0t watchdog expired", $time);
        miscompares++;
        summarize();
    end

    initial begin
        seed = 46293;
        {nrst_i, ce_i, sfr_wr_i, sfr_rd_i, cmp_async_i} = 5'h00;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        miscompares = 0;
        n_checks = 0;
        tick(6);
        ce_i = 1'b1;
        tick(1);
        nrst_i = 1'b1;
        chk(sfr_rdata_o, 8'h00, "rdata after reset");
        rd_chk(CMPC_CTRL_ADDR, CMPC_CTRL_RESET);
        $display("test reset done");
        // Every hysteresis pair, random enable and read-only bit 6
        for (int i = 0; i < 16; i++) begin
            w = 8'($random(seed));
            w[5:4] = 2'h0;
            w[3:0] = 4'(i);
            wr(CMPC_CTRL_ADDR, w);
            m = {w[7], 1'b0, w[5:0]};
            chk({7'h00, comparator_enable_o}, {7'h00, m[7]}, "enable");
            chk({6'h00, positive_hysteresis_sel_o}, {6'h00, m[3:2]}, "pos hys");
            chk({6'h00, negative_hysteresis_sel_o}, {6'h00, m[1:0]}, "neg hys");
            rd_chk(CMPC_CTRL_ADDR, exp_rd(m, 1'b0));
        end
        $display("test hysteresis done");
        // Ignored accesses leave register and read data alone
        wr(8'h9f, 8'hff);
        ce_i = 1'b0;
        wr(CMPC_CTRL_ADDR, 8'hff);
        ce_i = 1'b1;
        rd_chk(8'h9d, exp_rd(m, 1'b0));
        rd_chk(CMPC_CTRL_ADDR, exp_rd(m, 1'b0));
        $display("test ignored done");
        wr(CMPC_CTRL_ADDR, 8'h80);
        m = 8'h80;
        // Flags are not trusted until the analog side has settled
        tick(int'(CMPC_SETTLE_CYC));
        cmp_async_i = 1'b1;
        tick(4);
        m[5] = 1'b1;
        chk({7'h00, cmp_pin_o}, 8'h01, "pin high");
        rd_chk(CMPC_CTRL_ADDR, exp_rd(m, 1'b1));
        cmp_async_i = 1'b0;
        tick(4);
        m[4] = 1'b1;
        chk({7'h00, cmp_pin_o}, 8'h00, "pin low");
        rd_chk(CMPC_CTRL_ADDR, exp_rd(m, 1'b0));
        tick(20);
        rd_chk(CMPC_CTRL_ADDR, exp_rd(m, 1'b0));
        wr(CMPC_CTRL_ADDR, 8'h80);
        m = 8'h80;
        rd_chk(CMPC_CTRL_ADDR, exp_rd(m, 1'b0));
        $display("test edges done");
        // Disabled: no flags, pin held low, result still live
        wr(CMPC_CTRL_ADDR, 8'h00);
        cmp_async_i = 1'b1;
        tick(4);
        chk({7'h00, cmp_pin_o}, 8'h00, "pin off");
        rd_chk(CMPC_CTRL_ADDR, 8'h40);
        cmp_async_i = 1'b0;
        tick(4);
        rd_chk(CMPC_CTRL_ADDR, 8'h00);
        $display("test disabled done");
        // Mid-run reset wipes a fully dirty register
        wr(CMPC_CTRL_ADDR, 8'hbf);
        nrst_i = 1'b0;
        tick(3);
        nrst_i = 1'b1;
        chk({7'h00, comparator_enable_o}, 8'h00, "enable after reset");
        chk({4'h0, positive_hysteresis_sel_o, negative_hysteresis_sel_o}, 8'h00, "hys after reset");
        rd_chk(CMPC_CTRL_ADDR, CMPC_CTRL_RESET);
        $display("test reset again done");
        summarize();
    end
endmodule
`default_nettype wire
